// ---- hdl/touch_keypad_pkg.sv ----
// Shared constants and types for the touch screen and keypad pin logic
package touch_keypad_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADC_BITS   = 12;
  localparam int CMD_BITS   = 8;
  localparam int KEY_COLS   = 6;
  localparam int KEY_ROWS   = 5;
  localparam int COUNT_BITS = 16;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // Command layout
  // ----------------------------------------------------------------------
  localparam int CMD_START_BIT = 7;
  localparam int CMD_PHASE_MSB = 6;
  localparam int CMD_PHASE_LSB = 5;
  localparam int CMD_LAST_BIT  = 7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 25;
  localparam int MIN_SAMPLE_PERIOD_NS = 8000;
  localparam int MIN_SAMPLE_CYCLES    = (MIN_SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_TIME_NS       = 1500;
  localparam int SAMPLE_CYCLES        = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_TIME_NS     = 10000;
  localparam int DEBOUNCE_CYCLES      = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [KEY_COLS-1:0] COLUMNS_ALL_LOW = 6'h00;
  localparam logic [KEY_ROWS-1:0] ROWS_ALL_HIGH   = 5'h1f;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PHASE_X  = 2'h0,
    PHASE_Y  = 2'h1,
    PHASE_Z1 = 2'h2,
    PHASE_Z2 = 2'h3
  } phase_type;

  typedef enum logic [1:0] {
    PLATE_GROUND = 2'h0,
    PLATE_OPEN   = 2'h1,
    PLATE_DRIVE  = 2'h2,
    PLATE_ADC    = 2'h3
  } plate_type;

  typedef enum logic [3:0] {
    CONV_IDLE   = 4'h1,
    CONV_SAMPLE = 4'h2,
    CONV_RUN    = 4'h4,
    CONV_PUSH   = 4'h8
  } conv_state_type;

  typedef enum logic [2:0] {
    KEY_IDLE    = 3'h1,
    KEY_SCAN    = 3'h2,
    KEY_RELEASE = 3'h4
  } key_state_type;

endpackage

// ---- hdl/touch_keypad_pin_logic.sv ----
// Pin logic of a touch screen controller with keypad scanner, serial port and result FIFO
//
// Contract
// - Results are 12 bits; samples start no faster than 125 kHz.
// - Keypad matrix is at most 6 columns driven by 5 rows sensed.
// - Keypad interrupt goes low on key press when detection is allowed.
// - Keypad interrupt returns high when the debounce scan completes.
// - Keypad interrupt stays high whenever key interrupts are disabled.
// - Busy is high for the whole keypad debounce scan.
// - Busy is high from end of sampling until result MSB shifts out.
// - Serial data output changes on falling serial clock edges.
// - Serial output is low while selected and no result is shifting.
// - Serial output is released to high impedance while chip select is high.
// - Serial data input is captured on rising serial clock edges.
// - Commands are accepted only while chip select is low.
// - Device logic is reset while the reset input is low.
// - Pen interrupt goes low on touch while chip select is high.
// - Pen interrupt stays high when disabled or outside pen waiting state.
// - Y-minus plate drives for Y, opens for X, feeds converter for Z2.
// - Y-minus plate is grounded while waiting for a pen touch.

`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------------
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_type;

  fifo_type s;
  fifo_type next_s;

  logic full;
  logic empty;

  always_comb begin
    full      = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
    empty     = (s.wr == s.rd);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = s.mem[s.rd[AW-1:0]];
    next_s    = s;
    if (in_valid && !full) begin
      next_s.mem[s.wr[AW-1:0]] = in_data;
      next_s.wr                = s.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ------------------------------------------------------------------------
// Serial port on the host clock
// ------------------------------------------------------------------------
module serial_link (
  input  wire logic                                 serial_clk,
  input  wire logic                                 chip_select_n,
  input  wire logic                                 serial_data_in,
  input  wire logic                                 core_rst_n,
  input  wire logic                                 ready_toggle,
  input  wire logic [touch_keypad_pkg::ADC_BITS-1:0] result_word,
  output logic                                      cmd_toggle,
  output logic      [touch_keypad_pkg::CMD_BITS-1:0] cmd_word,
  output logic                                      ack_toggle,
  output logic                                      serial_data_out
);
  typedef struct packed {
    logic [3:0]                          count;
    logic [touch_keypad_pkg::CMD_BITS-1:0] shift;
  } rx_frame_type;

  typedef struct packed {
    logic                                  cmd_toggle;
    logic [touch_keypad_pkg::CMD_BITS-1:0] cmd_word;
    logic                                  ready_meta;
    logic                                  ready_sync;
  } rx_keep_type;

  typedef struct packed {
    logic [touch_keypad_pkg::ADC_BITS-1:0] shift;
    logic [3:0]                            left;
    logic                                  data;
  } tx_frame_type;

  rx_frame_type rxf;
  rx_frame_type next_rxf;
  rx_keep_type  rxk;
  rx_keep_type  next_rxk;
  tx_frame_type txf;
  tx_frame_type next_txf;
  logic         ack;
  logic         next_ack;
  logic         frame_rst_n;

  // The frame logic ends with the frame; the clock may stop once select rises
  assign frame_rst_n     = core_rst_n && !chip_select_n;
  assign cmd_toggle      = rxk.cmd_toggle;
  assign cmd_word        = rxk.cmd_word;
  assign ack_toggle      = ack;
  assign serial_data_out = txf.data;

  always_comb begin
    next_rxf            = rxf;
    next_rxk            = rxk;
    next_rxk.ready_meta = ready_toggle;
    next_rxk.ready_sync = rxk.ready_meta;
    if (rxf.count <= 4'(touch_keypad_pkg::CMD_LAST_BIT)) begin
      next_rxf.shift = {rxf.shift[touch_keypad_pkg::CMD_BITS-2:0], serial_data_in};
      next_rxf.count = rxf.count + 4'h1;
      if (rxf.count == 4'(touch_keypad_pkg::CMD_LAST_BIT)) begin
        next_rxk.cmd_word   = {rxf.shift[touch_keypad_pkg::CMD_BITS-2:0], serial_data_in};
        next_rxk.cmd_toggle = !rxk.cmd_toggle;
      end
    end
  end

  always_comb begin
    next_txf = txf;
    next_ack = ack;
    if (txf.left != 4'h0) begin
      next_txf.data  = txf.shift[touch_keypad_pkg::ADC_BITS-1];
      next_txf.shift = {txf.shift[touch_keypad_pkg::ADC_BITS-2:0], 1'b0};
      next_txf.left  = txf.left - 4'h1;
    end else begin
      next_txf.data = 1'b0;
      if (rxk.ready_sync != ack) begin
        next_txf.data  = result_word[touch_keypad_pkg::ADC_BITS-1];
        next_txf.shift = {result_word[touch_keypad_pkg::ADC_BITS-2:0], 1'b0};
        next_txf.left  = 4'(touch_keypad_pkg::ADC_BITS - 1);
        next_ack       = !ack;
      end
    end
  end

  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rxf <= '0;
    end else begin
      rxf <= next_rxf;
    end
  end

  always_ff @(posedge serial_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rxk <= '0;
    end else begin
      rxk <= next_rxk;
    end
  end

  always_ff @(negedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      txf <= '0;
    end else begin
      txf <= next_txf;
    end
  end

  always_ff @(negedge serial_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end
endmodule

// ------------------------------------------------------------------------
// Top: conversion control, keypad scanner, interrupts
// ------------------------------------------------------------------------
module touch_keypad_pin_logic #(
  parameter int SAMPLE_CYCLES   = touch_keypad_pkg::SAMPLE_CYCLES,
  parameter int DEBOUNCE_CYCLES = touch_keypad_pkg::DEBOUNCE_CYCLES,
  parameter int FIFO_DEPTH      = touch_keypad_pkg::FIFO_DEPTH
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 device_reset_n,
  input  wire logic                                 serial_clk,
  input  wire logic                                 chip_select_n,
  input  wire logic                                 serial_data_in,
  output logic                                      serial_data_out,
  output logic                                      serial_data_oe_n,
  output logic                                      busy,
  input  wire logic                                 touch_detect,
  input  wire logic                                 pen_irq_enable,
  output logic                                      touch_irq_n,
  input  wire logic                                 key_irq_enable,
  input  wire logic [touch_keypad_pkg::KEY_ROWS-1:0] key_row_n,
  output logic      [touch_keypad_pkg::KEY_COLS-1:0] key_column_n,
  output logic [touch_keypad_pkg::KEY_COLS*touch_keypad_pkg::KEY_ROWS-1:0] key_state,
  output logic                                      keypad_irq_n,
  output touch_keypad_pkg::plate_type               y_minus_plate,
  output touch_keypad_pkg::phase_type               measure_phase,
  output logic                                      adc_start,
  input  wire logic [touch_keypad_pkg::ADC_BITS-1:0] adc_data,
  input  wire logic                                 adc_done
);
  localparam int AB = touch_keypad_pkg::ADC_BITS;
  localparam int CB = touch_keypad_pkg::COUNT_BITS;
  localparam int KC = touch_keypad_pkg::KEY_COLS;
  localparam int KR = touch_keypad_pkg::KEY_ROWS;

  typedef struct packed {
    logic                             cs_meta;
    logic                             cs_sync;
    logic                             oe_n;
    logic                             touch_meta;
    logic                             touch_sync;
    logic [KR-1:0]                    row_meta;
    logic [KR-1:0]                    row_sync;
    logic                             cmd_meta;
    logic                             cmd_sync;
    logic                             cmd_seen;
    logic                             ack_meta;
    logic                             ack_sync;
    logic                             ack_seen;
    touch_keypad_pkg::conv_state_type conv;
    touch_keypad_pkg::phase_type      phase;
    logic [CB-1:0]                    conv_count;
    logic [CB-1:0]                    gap_count;
    logic [AB-1:0]                    result;
    logic                             adc_start;
    logic                             busy_conv;
    logic [AB-1:0]                    hold_word;
    logic                             hold_full;
    logic                             ready_toggle;
    touch_keypad_pkg::key_state_type  key;
    logic [2:0]                       key_col;
    logic [CB-1:0]                    key_count;
    logic [KC-1:0]                    columns_n;
    logic [KC*KR-1:0]                 keys;
    logic                             keypad_irq_n;
    logic                             key_busy;
    logic                             busy;
    logic                             touch_irq_n;
    touch_keypad_pkg::plate_type      plate;
  } core_type;

  core_type s;
  core_type next_s;
  logic     rst_meta;
  logic     rst_n;
  logic     fifo_in_ready;
  logic     fifo_out_valid;
  logic [AB-1:0] fifo_out_data;
  logic     link_cmd_toggle;
  logic [touch_keypad_pkg::CMD_BITS-1:0] link_cmd_word;
  logic     link_ack_toggle;

  function automatic logic [KC-1:0] column_mask(input logic [2:0] col);
    column_mask = ~(KC'(1) << col);
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // reset while low
  always_ff @(posedge core_clk or negedge device_reset_n) begin
    if (!device_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  serial_link u_link (
    .serial_clk      (serial_clk),
    .chip_select_n   (chip_select_n),
    .serial_data_in  (serial_data_in),
    .core_rst_n      (rst_n),
    .ready_toggle    (s.ready_toggle),
    .result_word     (s.hold_word),
    .cmd_toggle      (link_cmd_toggle),
    .cmd_word        (link_cmd_word),
    .ack_toggle      (link_ack_toggle),
    .serial_data_out (serial_data_out)
  );

  // Full FIFO stalls new conversions rather than dropping results
  result_fifo #(
    .WIDTH (AB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_valid  (s.conv == touch_keypad_pkg::CONV_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (s.result),
    .out_valid (fifo_out_valid),
    .out_ready (!s.hold_full),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s            = s;
    next_s.cs_meta    = chip_select_n;
    next_s.cs_sync    = s.cs_meta;
    next_s.oe_n       = s.cs_sync;
    next_s.touch_meta = touch_detect;
    next_s.touch_sync = s.touch_meta;
    next_s.row_meta   = key_row_n;
    next_s.row_sync   = s.row_meta;
    next_s.cmd_meta   = link_cmd_toggle;
    next_s.cmd_sync   = s.cmd_meta;
    next_s.ack_meta   = link_ack_toggle;
    next_s.ack_sync   = s.ack_meta;
    next_s.adc_start  = 1'b0;

    if (s.gap_count != '0) begin
      next_s.gap_count = s.gap_count - 1'b1;
    end

    // Hand the next result to the link; word stays put until acknowledged
    if (!s.hold_full && fifo_out_valid) begin
      next_s.hold_word    = fifo_out_data;
      next_s.hold_full    = 1'b1;
      next_s.ready_toggle = !s.ready_toggle;
    end
    if (s.ack_sync != s.ack_seen) begin
      next_s.ack_seen  = s.ack_sync;
      next_s.hold_full = 1'b0;
      next_s.busy_conv = 1'b0;
    end

    case (s.conv)
      touch_keypad_pkg::CONV_IDLE: begin
        if (s.cmd_sync != s.cmd_seen && s.gap_count == '0) begin
          next_s.cmd_seen = s.cmd_sync;
          if (link_cmd_word[touch_keypad_pkg::CMD_START_BIT]) begin
            next_s.phase = touch_keypad_pkg::phase_type'(
              link_cmd_word[touch_keypad_pkg::CMD_PHASE_MSB:touch_keypad_pkg::CMD_PHASE_LSB]);
            next_s.conv       = touch_keypad_pkg::CONV_SAMPLE;
            next_s.conv_count = CB'(SAMPLE_CYCLES - 1);
            next_s.gap_count  = CB'(touch_keypad_pkg::MIN_SAMPLE_CYCLES - 1);
          end
        end
      end
      touch_keypad_pkg::CONV_SAMPLE: begin
        if (s.conv_count == '0) begin
          next_s.busy_conv = 1'b1;
          next_s.adc_start = 1'b1;
          next_s.conv      = touch_keypad_pkg::CONV_RUN;
        end else begin
          next_s.conv_count = s.conv_count - 1'b1;
        end
      end
      touch_keypad_pkg::CONV_RUN: begin
        if (adc_done) begin
          next_s.result = adc_data;
          next_s.conv   = touch_keypad_pkg::CONV_PUSH;
        end
      end
      touch_keypad_pkg::CONV_PUSH: begin
        if (fifo_in_ready) begin
          next_s.conv = touch_keypad_pkg::CONV_IDLE;
        end
      end
      default: begin
        next_s.conv = touch_keypad_pkg::CONV_IDLE;
      end
    endcase

    case (next_s.conv)
      touch_keypad_pkg::CONV_SAMPLE, touch_keypad_pkg::CONV_RUN: begin
        case (next_s.phase)
          touch_keypad_pkg::PHASE_X:  next_s.plate = touch_keypad_pkg::PLATE_OPEN;
          touch_keypad_pkg::PHASE_Z2: next_s.plate = touch_keypad_pkg::PLATE_ADC;
          default:                    next_s.plate = touch_keypad_pkg::PLATE_DRIVE;
        endcase
      end
      default: begin
        next_s.plate = touch_keypad_pkg::PLATE_GROUND;
      end
    endcase

    // disabled or measuring
    // Next state, so the interrupt never shows while the plate is off ground
    next_s.touch_irq_n = !(pen_irq_enable && s.touch_sync && s.cs_sync
                           && next_s.conv == touch_keypad_pkg::CONV_IDLE);

    case (s.key)
      touch_keypad_pkg::KEY_IDLE: begin
        next_s.columns_n = touch_keypad_pkg::COLUMNS_ALL_LOW;
        if (key_irq_enable && s.row_sync != touch_keypad_pkg::ROWS_ALL_HIGH) begin
          next_s.keypad_irq_n = 1'b0;
          next_s.key_busy     = 1'b1;
          next_s.key          = touch_keypad_pkg::KEY_SCAN;
          next_s.key_col      = 3'h0;
          next_s.key_count    = CB'(DEBOUNCE_CYCLES - 1);
          next_s.columns_n    = column_mask(3'h0);
        end
      end
      touch_keypad_pkg::KEY_SCAN: begin
        if (s.key_count == '0) begin
          next_s.keys[s.key_col*KR +: KR] = ~s.row_sync;
          if (s.key_col == 3'(KC - 1)) begin
            next_s.keypad_irq_n = 1'b1;
            next_s.key_busy     = 1'b0;
            next_s.columns_n    = touch_keypad_pkg::COLUMNS_ALL_LOW;
            next_s.key          = touch_keypad_pkg::KEY_RELEASE;
          end else begin
            next_s.key_col   = s.key_col + 3'h1;
            next_s.columns_n = column_mask(s.key_col + 3'h1);
            next_s.key_count = CB'(DEBOUNCE_CYCLES - 1);
          end
        end else begin
          next_s.key_count = s.key_count - 1'b1;
        end
      end
      touch_keypad_pkg::KEY_RELEASE: begin
        // Detection is re-armed only after every key is let go
        if (s.row_sync == touch_keypad_pkg::ROWS_ALL_HIGH) begin
          next_s.key = touch_keypad_pkg::KEY_IDLE;
        end
      end
      default: begin
        next_s.key = touch_keypad_pkg::KEY_IDLE;
      end
    endcase

    if (!key_irq_enable) begin
      next_s.keypad_irq_n = 1'b1;
    end

    next_s.busy = next_s.busy_conv || next_s.key_busy;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s              <= '0;
      s.cs_meta      <= 1'b1;
      s.cs_sync      <= 1'b1;
      s.oe_n         <= 1'b1;
      s.row_meta     <= touch_keypad_pkg::ROWS_ALL_HIGH;
      s.row_sync     <= touch_keypad_pkg::ROWS_ALL_HIGH;
      s.conv         <= touch_keypad_pkg::CONV_IDLE;
      s.phase        <= touch_keypad_pkg::PHASE_X;
      s.key          <= touch_keypad_pkg::KEY_IDLE;
      s.columns_n    <= touch_keypad_pkg::COLUMNS_ALL_LOW;
      s.keypad_irq_n <= 1'b1;
      s.touch_irq_n  <= 1'b1;
      s.plate        <= touch_keypad_pkg::PLATE_GROUND;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign serial_data_oe_n = s.oe_n;
  assign busy             = s.busy;
  assign touch_irq_n      = s.touch_irq_n;
  assign key_column_n     = s.columns_n;
  assign key_state        = s.keys;
  assign keypad_irq_n     = s.keypad_irq_n;
  assign y_minus_plate    = s.plate;
  assign measure_phase    = s.phase;
  assign adc_start        = s.adc_start;
endmodule

// ---- sim/touch_keypad_properties.sv ----
// Checker of the pin behaviour seen at the top module ports
`timescale 1ns/1ps
module touch_keypad_properties (
  input wire logic              core_clk,
  input wire logic              device_reset_n,
  input wire logic              chip_select_n,
  input wire logic              serial_data_oe_n,
  input wire logic              busy,
  input wire logic              pen_irq_enable,
  input wire logic              touch_irq_n,
  input wire logic              key_irq_enable,
  input wire logic              keypad_irq_n,
  input touch_keypad_pkg::plate_type y_minus_plate,
  input touch_keypad_pkg::phase_type measure_phase,
  input wire logic              adc_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!device_reset_n);
  sequence conv_begin;
    adc_start;
  endsequence
  a_start_busy: assert property (conv_begin |-> busy)
    else $error("busy low at conversion start");
  a_plate_phase: assert property (conv_begin |-> y_minus_plate ==
    (measure_phase == touch_keypad_pkg::PHASE_X ? touch_keypad_pkg::PLATE_OPEN :
     measure_phase == touch_keypad_pkg::PHASE_Z2 ? touch_keypad_pkg::PLATE_ADC :
     touch_keypad_pkg::PLATE_DRIVE)) else $error("plate wrong for phase");
  a_plate_wait: assert property (!touch_irq_n |->
    y_minus_plate == touch_keypad_pkg::PLATE_GROUND) else $error("plate not grounded");
  a_pen_off: assert property (!pen_irq_enable [*4] |-> touch_irq_n)
    else $error("pen irq low while disabled");
  a_pen_fall: assert property ($fell(touch_irq_n) |-> $past(pen_irq_enable))
    else $error("pen irq fell without enable");
  a_key_off: assert property (!key_irq_enable |=> keypad_irq_n)
    else $error("key irq low while disabled");
  a_key_fall: assert property ($fell(keypad_irq_n) |-> $past(key_irq_enable) && busy)
    else $error("key irq fell wrongly");
  a_scan_busy: assert property (!keypad_irq_n |-> busy)
    else $error("busy low during key scan");
  a_out_release: assert property (chip_select_n [*5] |-> serial_data_oe_n)
    else $error("output driven while deselected");
endmodule
bind touch_keypad_pin_logic touch_keypad_properties u_props (.core_clk, .device_reset_n,
  .chip_select_n, .serial_data_oe_n, .busy, .pen_irq_enable, .touch_irq_n, .key_irq_enable,
  .keypad_irq_n, .y_minus_plate, .measure_phase, .adc_start);

// ---- sim/host_model.sv ----
// Host side of the serial port: one command and one result word per frame
`timescale 1ns/1ps
module host_model (
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock stands still outside frames; the word starts at the first 1 after idle zeros
  task automatic frame(input logic [7:0] cmd, output logic [11:0] word);
    int n;
    n = 0;
    word = 12'h000;
    chip_select_n = 1'b0;
    #107;
    for (int i = 0; i < 48 && n < 12; i++) begin
      serial_data_in = (i < 8) ? cmd[7-i] : 1'b0;
      #62.5 serial_clk = 1'b1;
      if (n > 0 || serial_data_out === 1'b1) begin
        word = {word[10:0], serial_data_out};
        n++;
      end
      #62.5 serial_clk = 1'b0;
    end
    chip_select_n = 1'b1;
    #193;
  endtask
endmodule

// ---- sim/tb_touch_keypad_pin_logic.sv ----
// Self-checking bench for the touch screen and keypad pin logic
`timescale 1ns/1ps
module tb_touch_keypad_pin_logic;
  logic core_clk = 1'b0, device_reset_n = 1'b0, touch_detect = 1'b0, pen_irq_enable = 1'b0;
  logic key_irq_enable = 1'b0, press = 1'b0, adc_done = 1'b0;
  logic serial_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_oe_n;
  logic busy, touch_irq_n, keypad_irq_n, adc_start, host_line;
  logic [4:0]  key_row_n;
  logic [5:0]  key_column_n;
  logic [29:0] key_state;
  logic [11:0] word;
  touch_keypad_pkg::plate_type y_minus_plate;
  touch_keypad_pkg::phase_type measure_phase;
  int failures = 0, samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  // Pressed key sits at column 2, row 3
  assign key_row_n = (press && key_column_n[2] === 1'b0) ? 5'h17 : 5'h1f;
  always @(posedge core_clk) adc_done <= adc_start;
  // Released line shows the inverse, so a late output enable corrupts the word
  assign host_line = serial_data_oe_n ? ~serial_data_out : serial_data_out;
  host_model host (.serial_clk, .chip_select_n, .serial_data_in, .serial_data_out(host_line));
  touch_keypad_pin_logic #(.SAMPLE_CYCLES(4), .DEBOUNCE_CYCLES(4), .FIFO_DEPTH(16)) dut (
    .core_clk, .device_reset_n, .serial_clk, .chip_select_n, .serial_data_in,
    .serial_data_out, .serial_data_oe_n, .busy, .touch_detect, .pen_irq_enable, .touch_irq_n,
    .key_irq_enable, .key_row_n, .key_column_n, .key_state, .keypad_irq_n, .y_minus_plate,
    .measure_phase, .adc_start, .adc_data(12'hc35), .adc_done);
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      failures++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask
  task automatic results();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_key(input logic v);
    for (int i = 0; i < 300 && keypad_irq_n !== v; i++) @(negedge core_clk);
    if (keypad_irq_n !== v) begin
      failures++;
      results();
    end
  endtask
  task automatic pen();
    pen_irq_enable = 1'b1;
    touch_detect = 1'b1;
    cycles(6);
    check(touch_irq_n, 0);
    check(y_minus_plate, 0);
    pen_irq_enable = 1'b0;
    cycles(6);
    check(touch_irq_n, 1);
    touch_detect = 1'b0;
  endtask
  task automatic keypad();
    key_irq_enable = 1'b1;
    press = 1'b1;
    wait_key(1'b0);
    check(busy, 1);
    wait_key(1'b1);
    check(busy, 0);
    check(key_state, 32'h2000);
    press = 1'b0;
    cycles(10);
    key_irq_enable = 1'b0;
    press = 1'b1;
    cycles(40);
    check(keypad_irq_n, 1);
    key_irq_enable = 1'b1;
    wait_key(1'b0);
    device_reset_n = 1'b0;
    cycles(3);
    check(keypad_irq_n, 1);
    check(key_state, 0);
    press = 1'b0;
    device_reset_n = 1'b1;
    cycles(6);
  endtask
  task automatic conversions();
    for (int p = 0; p < 4; p++) begin
      host.frame({1'b1, 2'(p), 5'h00}, word);
      check(word, 32'hc35);
      check(measure_phase, 32'(p));
      cycles(10);
      check(busy, 0);
      check(serial_data_oe_n, 1);
      cycles(340);
    end
    host.frame(8'h20, word);
    check(word, 0);
    check(measure_phase, 3);
  endtask
  initial begin
    cycles(6);
    device_reset_n = 1'b1;
    cycles(4);
    pen();
    keypad();
    conversions();
    results();
  end
endmodule
